//--- pkg/ssic_pkg.sv
// Package for the step indexer control block: pin bit positions,
// reset values, timing constants and the step resolution decode.
// Assumes a single core clock at 200 MHz; all pins are asynchronous.
package ssic_pkg;

	// Core clock period in picoseconds (200 MHz)
	localparam int CLK_PERIOD_PS = 5000;

	// Sleep entry time in microseconds, longest time rounds down
	localparam int SLEEP_ENTRY_US     = 100;
	localparam int SLEEP_ENTRY_CYCLES =
		(SLEEP_ENTRY_US * 1000000) / CLK_PERIOD_PS;

	// Wake-up time in milliseconds, longest time rounds down
	localparam int WAKE_MS     = 10;
	localparam int WAKE_CYCLES =
		(WAKE_MS * 1000000) / (CLK_PERIOD_PS / 1000); // No int overflow

	// Counter width covers the wake count
	localparam int CNT_W = 21;

	// Cycles lost to the pin synchroniser and the state hand-off;
	// taken off each count so pin-to-state time stays inside the limit
	localparam int SEQ_OVERHEAD_CYCLES = 4;

	// Positions in one electrical cycle, in finest step units
	localparam int POS_W = 7;
	localparam logic [POS_W-1:0] POS_INIT = 7'h00;

	// Bit positions of the synchronised pin vector
	localparam int PIN_W        = 10;
	localparam int PIN_STEP     = 0;
	localparam int PIN_DIR      = 1;
	localparam int PIN_ENABLE   = 2;
	localparam int PIN_ARESET   = 3;
	localparam int PIN_SLEEP_N  = 4;
	localparam int PIN_SEL0     = 5;
	localparam int PIN_SEL1     = 6;
	localparam int PIN_SEL2     = 7;
	localparam int PIN_THERMAL  = 8;
	localparam int PIN_OVERCUR  = 9;
	// Idle pin levels; sleep request released so reset does not dip
	localparam logic [PIN_W-1:0] PIN_RESET_VAL = 10'h010;

	// Step increments in finest units per resolution
	localparam logic [POS_W-1:0] INC_FULL    = 7'h20;
	localparam logic [POS_W-1:0] INC_HALF    = 7'h10;
	localparam logic [POS_W-1:0] INC_QUARTER = 7'h08;
	localparam logic [POS_W-1:0] INC_EIGHTH  = 7'h04;
	localparam logic [POS_W-1:0] INC_16TH    = 7'h02;
	localparam logic [POS_W-1:0] INC_32ND    = 7'h01;

	// Power state of the block
	typedef enum logic [1:0] {
		ST_RUN,
		ST_ENTRY,
		ST_SLEEP,
		ST_WAKE
	} ssic_state_t;

	// Resolution select {sel0,sel1,sel2} to position increment
	function automatic logic [POS_W-1:0] ssic_inc(
		input logic [2:0] sel
	);
		logic [POS_W-1:0] inc;
		inc = INC_32ND;
		unique case (sel)
			3'h0: inc = INC_FULL;
			3'h1: inc = INC_HALF;
			3'h2: inc = INC_HALF;
			3'h3: inc = INC_QUARTER;
			3'h4: inc = INC_EIGHTH;
			3'h5: inc = INC_16TH;
			3'h6: inc = INC_32ND;
			3'h7: inc = INC_32ND;
		endcase
		return inc;
	endfunction : ssic_inc

endpackage : ssic_pkg

//--- verilog/ssic_top.sv
// Step indexer control logic of a two-phase stepper driver.
// Assumes every input except core_clk and reset_n is an asynchronous pin.
module ssic_top
	import ssic_pkg::*;
#(
	parameter int SLEEP_ENTRY_CYC = SLEEP_ENTRY_CYCLES,
	parameter int WAKE_CYC        = WAKE_CYCLES
) (
	input  wire logic             core_clk,             // 200 MHz clock
	input  wire logic             reset_n,              // Async reset
	input  wire logic             step_pulse,           // Step clock pin
	input  wire logic             rotation_direction,   // High forward
	input  wire logic             motor_enable,         // High bridges on
	input  wire logic             angle_reset,          // High to initial
	input  wire logic             sleep_req_n,          // Low requests sleep
	input  wire logic             step_resolution_sel0, // Resolution bit 2
	input  wire logic             step_resolution_sel1, // Resolution bit 1
	input  wire logic             step_resolution_sel2, // Resolution bit 0
	input  wire logic             thermal_shutdown,     // Thermal sensor
	input  wire logic             overcurrent_detect,   // Current sensor
	output logic                  fault_flag_first,     // Thermal latched
	output logic                  fault_flag_second,    // Overcurrent latched
	output logic                  angle_monitor_out,    // High at initial
	output logic [POS_W-1:0]      step_position,        // Electrical angle
	output logic                  bridge_on,            // Output stage on
	output logic                  bridge_hiz,           // Outputs floating
	output logic                  charge_pump_on,       // Pump running
	output logic                  regulator_on,         // Logic supply on
	output logic                  sleep_active,         // In sleep mode
	output logic                  run_ready             // Normal operation
);

	////////////////////////////////////////////////////////////////////
	// State record

	typedef struct packed {
		logic [PIN_W-1:0] sync1;
		logic [PIN_W-1:0] sync2;
		logic             step_prev;
		ssic_state_t      state;
		logic [CNT_W-1:0] cnt;
		logic [POS_W-1:0] pos;
		logic             flt_thermal;
		logic             flt_overcur;
		logic             mon;
		logic             br_on;
		logic             br_hiz;
		logic             cp_on;
		logic             reg_on;
		logic             asleep;
		logic             ready;
	} ssic_regs_t;

	// Counts shortened by the pin and hand-off latency
	localparam logic [CNT_W-1:0] ENTRY_LAST =
		CNT_W'(SLEEP_ENTRY_CYC - SEQ_OVERHEAD_CYCLES);
	localparam logic [CNT_W-1:0] WAKE_LAST  =
		CNT_W'(WAKE_CYC - SEQ_OVERHEAD_CYCLES);
	localparam logic [CNT_W-1:0] CNT_ZERO   = 21'h000000;

	ssic_regs_t r_q;
	ssic_regs_t r_d;

	logic [PIN_W-1:0] pins;
	logic             step_edge;
	logic             stepping;
	logic [POS_W-1:0] inc;

	// Gather pins into one vector for the synchroniser
	assign pins = {overcurrent_detect, thermal_shutdown,
		step_resolution_sel2, step_resolution_sel1,
		step_resolution_sel0, sleep_req_n, angle_reset,
		motor_enable, rotation_direction, step_pulse};

	// Edge from the second stage only; first stage feeds nothing else
	assign step_edge = r_q.sync2[PIN_STEP] & ~r_q.step_prev;
	assign stepping  = (r_q.state == ST_RUN) || (r_q.state == ST_ENTRY);
	assign inc = ssic_inc({r_q.sync2[PIN_SEL0], r_q.sync2[PIN_SEL1],
		r_q.sync2[PIN_SEL2]});

	////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		r_d           = r_q;
		r_d.sync1     = pins;
		r_d.sync2     = r_q.sync1;
		r_d.step_prev = r_q.sync2[PIN_STEP];

		// Power sequencing; step input ignored until awake
		unique case (r_q.state)
			ST_RUN: begin
				r_d.cnt = CNT_ZERO;
				if (!r_q.sync2[PIN_SLEEP_N]) begin
					r_d.state = ST_ENTRY;
				end
			end
			ST_ENTRY: begin
				r_d.cnt = r_q.cnt + 21'h000001;
				if (r_q.sync2[PIN_SLEEP_N]) begin
					r_d.state = ST_RUN;
				end else if (r_q.cnt >= ENTRY_LAST) begin
					r_d.state = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				r_d.cnt = CNT_ZERO;
				if (r_q.sync2[PIN_SLEEP_N]) begin
					r_d.state = ST_WAKE;
				end
			end
			ST_WAKE: begin
				r_d.cnt = r_q.cnt + 21'h000001;
				if (!r_q.sync2[PIN_SLEEP_N]) begin
					r_d.state = ST_SLEEP;
				end else if (r_q.cnt >= WAKE_LAST) begin
					r_d.state = ST_RUN;
				end
			end
		endcase

		// Faults latch; only sleep clears them, a live sensor wins
		if (r_q.state == ST_SLEEP) begin
			r_d.flt_thermal = r_q.sync2[PIN_THERMAL];
			r_d.flt_overcur = r_q.sync2[PIN_OVERCUR];
		end else begin
			r_d.flt_thermal = r_q.flt_thermal | r_q.sync2[PIN_THERMAL];
			r_d.flt_overcur = r_q.flt_overcur | r_q.sync2[PIN_OVERCUR];
		end

		// Position: reset dominates, then a rising step edge
		if (r_q.sync2[PIN_ARESET]) begin
			r_d.pos = POS_INIT;
		end else if (step_edge && stepping) begin
			if (r_q.sync2[PIN_DIR]) begin
				r_d.pos = r_q.pos + inc;
			end else begin
				r_d.pos = r_q.pos - inc;
			end
		end

		// Outputs follow the next state so they switch together
		r_d.mon    = (r_d.pos == POS_INIT);
		r_d.br_on  = (r_d.state == ST_RUN) && r_q.sync2[PIN_ENABLE] &&
			!r_d.flt_thermal && !r_d.flt_overcur;
		r_d.br_hiz = !r_d.br_on;
		r_d.cp_on  = (r_d.state != ST_SLEEP);
		r_d.reg_on = (r_d.state != ST_SLEEP);
		r_d.asleep = (r_d.state == ST_SLEEP);
		r_d.ready  = (r_d.state == ST_RUN);
	end

	////////////////////////////////////////////////////////////////////
	// Registers

	// Power-up starts in wake so the regulator settles first
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			r_q.sync1       <= PIN_RESET_VAL;
			r_q.sync2       <= PIN_RESET_VAL;
			r_q.step_prev   <= 1'b0;
			r_q.state       <= ST_WAKE;
			r_q.cnt         <= CNT_ZERO;
			r_q.pos         <= POS_INIT;
			r_q.flt_thermal <= 1'b0;
			r_q.flt_overcur <= 1'b0;
			r_q.mon         <= 1'b1;
			r_q.br_on       <= 1'b0;
			r_q.br_hiz      <= 1'b1;
			r_q.cp_on       <= 1'b1;
			r_q.reg_on      <= 1'b1;
			r_q.asleep      <= 1'b0;
			r_q.ready       <= 1'b0;
		end else begin
			r_q <= r_d;
		end
	end

	// Outputs straight from the record
	assign fault_flag_first  = r_q.flt_thermal;
	assign fault_flag_second = r_q.flt_overcur;
	assign angle_monitor_out = r_q.mon;
	assign step_position     = r_q.pos;
	assign bridge_on         = r_q.br_on;
	assign bridge_hiz        = r_q.br_hiz;
	assign charge_pump_on    = r_q.cp_on;
	assign regulator_on      = r_q.reg_on;
	assign sleep_active      = r_q.asleep;
	assign run_ready         = r_q.ready;

	////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	// Thermal fault never drops outside sleep
	fault_hold_a: assert property (
		r_q.flt_thermal && r_q.state != ST_SLEEP |=> r_q.flt_thermal
	) else $error("thermal fault cleared without sleep");

	// Entry count done with sleep still requested: asleep next cycle
	sleep_entry_a: assert property (
		r_q.state == ST_ENTRY && r_q.cnt >= ENTRY_LAST &&
		!r_q.sync2[PIN_SLEEP_N] |=> sleep_active && !run_ready
	) else $error("sleep entry took too long");

	// Wake count done with sleep released: running next cycle
	wake_time_a: assert property (
		r_q.state == ST_WAKE && r_q.cnt >= WAKE_LAST &&
		r_q.sync2[PIN_SLEEP_N] |=> run_ready && !sleep_active
	) else $error("wake-up took too long");

	// No supplies in sleep, and the bridges float
	sleep_power_a: assert property (
		r_q.asleep |-> !charge_pump_on && !regulator_on && bridge_hiz
	) else $error("supplies running in sleep");

	// Rising edge moves by the decoded increment in the set direction
	step_move_a: assert property (
		step_edge && stepping && !r_q.sync2[PIN_ARESET] |=>
		step_position == ($past(r_q.sync2[PIN_DIR]) ?
		POS_W'($past(step_position) + $past(inc)) :
		POS_W'($past(step_position) - $past(inc)))
	) else $error("step moved wrongly");

	// Without an edge the position holds
	step_hold_a: assert property (
		!step_edge && !r_q.sync2[PIN_ARESET] |=> $stable(step_position)
	) else $error("position moved without edge");

	// Enable low forces the bridges off within a cycle
	enable_off_a: assert property (
		!r_q.sync2[PIN_ENABLE] |=> !bridge_on && bridge_hiz
	) else $error("bridge on with enable low");

	// Enable high in run with no fault turns the bridges on
	enable_on_a: assert property (
		r_q.sync2[PIN_ENABLE] && r_d.state == ST_RUN &&
		!r_d.flt_thermal && !r_d.flt_overcur |=> bridge_on
	) else $error("bridge off with enable high");

	// Angle reset returns to the initial position and monitor high
	angle_reset_a: assert property (
		r_q.sync2[PIN_ARESET] |=> step_position == POS_INIT &&
		angle_monitor_out
	) else $error("angle reset ignored");

	// Overcurrent event shows on its flag next cycle
	fault_flag_a: assert property (
		r_q.sync2[PIN_OVERCUR] |=> fault_flag_second
	) else $error("overcurrent flag missing");

	// Full step resolution uses quarter-cycle increments
	full_step_a: assert property (
		r_q.sync2[PIN_SEL2:PIN_SEL0] == 3'h0 |-> inc == INC_FULL
	) else $error("full step decode wrong");

	// Main scenarios
	cover_sleep_c: cover property (r_q.state == ST_ENTRY ##1
		r_q.state == ST_SLEEP);
	cover_fault_clr_c: cover property (r_q.flt_thermal ##1
		r_q.asleep ##1 !r_q.flt_thermal);
	cover_wrap_c: cover property (step_edge && stepping &&
		r_q.pos == 7'h7f && r_q.sync2[PIN_DIR]);
	cover_run_c: cover property ($rose(run_ready));

endmodule : ssic_top

//--- bench/ssic_ctrl_model.sv
// Partner model: a motion controller that sends step pulses on request.
// Assumes the bench loads a count with a one-cycle valid strobe.
module ssic_ctrl_model (
	input  wire logic       core_clk,   // Core clock
	input  wire logic       reset_n,    // Async reset
	input  wire logic       run_ready,  // Driver in normal operation
	input  wire logic       req_valid,  // Load a new count
	input  wire logic [7:0] req_count,  // Pulses to send
	output logic            step_pulse, // Step clock pin
	output logic            busy        // Pulses outstanding
);
	logic [7:0] left_q; // Pulses still owed
	logic [2:0] ph_q;   // Phase within one pulse

	assign busy = (left_q != 8'h00);

	// Four cycles high, four low: the pin synchroniser needs three
	// stable cycles, so nothing shorter is offered
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			left_q     <= 8'h00;
			ph_q       <= 3'h0;
			step_pulse <= 1'b0;
		end else if (req_valid) begin
			left_q <= req_count;
		end else if (busy && run_ready) begin
			ph_q <= ph_q + 3'h1;
			if (ph_q == 3'h3)
				step_pulse <= 1'b1;
			if (ph_q == 3'h7) begin
				step_pulse <= 1'b0;
				left_q     <= left_q - 8'h01;
			end
		end
	end
endmodule : ssic_ctrl_model

//--- bench/test_stepper_step_indexer_control.sv
// Self-checking bench for the step indexer control block.
// Assumes shortened sleep and wake counts; pins change at rising edges.
module test_stepper_step_indexer_control
	import ssic_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic             core_clk           = 1'b0;
	logic             reset_n            = 1'b0;
	logic             rotation_direction = 1'b1;
	logic             motor_enable       = 1'b0;
	logic             angle_reset        = 1'b0;
	logic             sleep_req_n        = 1'b1;
	logic             thermal_shutdown   = 1'b0;
	logic             overcurrent_detect = 1'b0;
	logic             req_valid          = 1'b0;
	logic [7:0]       req_count          = 8'h00;
	logic [2:0]       sel                = 3'h0;
	logic             step_pulse, busy, fault_flag_first;
	logic             fault_flag_second, angle_monitor_out, bridge_on;
	logic             bridge_hiz, charge_pump_on, regulator_on;
	logic             sleep_active, run_ready;
	logic [POS_W-1:0] step_position;
	int               mismatches         = 0;
	int               total_checks       = 0;

	// 200 MHz core clock
	always #2.5 core_clk = ~core_clk;

	////////////////////////////////////////////////////////////////////////
	// Device and controller; short counts keep the run brief
	ssic_top #(.SLEEP_ENTRY_CYC(8), .WAKE_CYC(16)) dut (
		.core_clk, .reset_n, .step_pulse, .rotation_direction,
		.motor_enable, .angle_reset, .sleep_req_n,
		.step_resolution_sel0(sel[2]), .step_resolution_sel1(sel[1]),
		.step_resolution_sel2(sel[0]), .thermal_shutdown,
		.overcurrent_detect, .fault_flag_first, .fault_flag_second,
		.angle_monitor_out, .step_position, .bridge_on, .bridge_hiz,
		.charge_pump_on, .regulator_on, .sleep_active, .run_ready);
	ssic_ctrl_model ctrl (.core_clk, .reset_n, .run_ready, .req_valid,
		.req_count, .step_pulse, .busy);

	////////////////////////////////////////////////////////////////////////
	// Shared helpers
	task automatic chk(input logic [POS_W-1:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Ends at a falling edge, where outputs have settled
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		@(negedge core_clk);
	endtask : cyc

	// Guard of two edges: busy only rises once the model took the count
	task automatic steps(input logic [7:0] n);
		@(posedge core_clk);
		req_count <= n;
		req_valid <= 1'b1;
		@(posedge core_clk);
		req_valid <= 1'b0;
		for (int i = 0; i < 4000 && (busy !== 1'b0 || i < 2); i++)
			@(posedge core_clk);
		cyc(4);
	endtask : steps

	////////////////////////////////////////////////////////////////////////
	// Every resolution code, one step forward and one back
	task automatic t_res();
		logic [POS_W-1:0] inc [8] = '{7'h20, 7'h10, 7'h10, 7'h08,
			7'h04, 7'h02, 7'h01, 7'h01};
		for (int s = 0; s < 8; s++) begin
			@(posedge core_clk);
			sel <= 3'(s);
			rotation_direction <= 1'b1;
			steps(8'h01);
			chk(step_position, inc[s]);
			chk(POS_W'(angle_monitor_out), 7'h00);
			@(posedge core_clk);
			rotation_direction <= 1'b0;
			steps(8'h01);
			chk(step_position, POS_INIT);
			chk(POS_W'(angle_monitor_out), 7'h01);
		end
	endtask : t_res

	// Wrap below zero, several whole pulses, then the reset pin
	task automatic t_wrap();
		steps(8'h01);
		chk(step_position, 7'h7f);
		@(posedge core_clk);
		sel <= 3'h0;
		rotation_direction <= 1'b1;
		steps(8'h05);
		chk(step_position, 7'h1f);
		@(posedge core_clk);
		angle_reset <= 1'b1;
		cyc(4);
		chk(step_position, POS_INIT);
		@(posedge core_clk);
		angle_reset <= 1'b0;
	endtask : t_wrap

	task automatic t_enable();
		@(posedge core_clk);
		motor_enable <= 1'b1;
		cyc(5);
		chk(POS_W'({bridge_on, bridge_hiz}), 7'h02);
		@(posedge core_clk);
		motor_enable <= 1'b0;
		cyc(5);
		chk(POS_W'({bridge_on, bridge_hiz}), 7'h01);
		@(posedge core_clk);
		motor_enable <= 1'b1;
	endtask : t_enable

	// A short sleep dip must not clear the fault; a full sleep must
	task automatic t_fault(input logic ovc);
		@(posedge core_clk);
		overcurrent_detect <= ovc;
		thermal_shutdown <= !ovc;
		repeat (3) @(posedge core_clk);
		overcurrent_detect <= 1'b0;
		thermal_shutdown <= 1'b0;
		sleep_req_n <= 1'b0;
		@(posedge core_clk);
		sleep_req_n <= 1'b1;
		cyc(6);
		chk(POS_W'({fault_flag_second, fault_flag_first}),
			ovc ? 7'h02 : 7'h01);
		chk(POS_W'(bridge_on), 7'h00);
		@(posedge core_clk);
		sleep_req_n <= 1'b0;
		// Eight cycles is the shortened sleep entry time
		for (int i = 0; i < 8 && sleep_active !== 1'b1; i++)
			cyc(1);
		chk(POS_W'(sleep_active), 7'h01);
		chk(POS_W'({charge_pump_on, regulator_on}), 7'h00);
		// Flags clear one cycle into sleep
		cyc(1);
		chk(POS_W'({fault_flag_second, fault_flag_first}), 7'h00);
		@(posedge core_clk);
		sleep_req_n <= 1'b1;
		// Sixteen cycles is the shortened wake time
		for (int i = 0; i < 16 && run_ready !== 1'b1; i++)
			cyc(1);
		cyc(1);
		chk(POS_W'(run_ready), 7'h01);
		chk(POS_W'({charge_pump_on, regulator_on}), 7'h03);
		chk(POS_W'(bridge_on), 7'h01);
	endtask : t_fault

	////////////////////////////////////////////////////////////////////////
	// Verdict, reached from the main sequence or the watchdog
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up

	// Main sequence: reset values, wake, then the scenarios
	initial begin
		cyc(15);
		chk(POS_W'({bridge_hiz, charge_pump_on}), 7'h03);
		chk(POS_W'(angle_monitor_out), 7'h01);
		@(posedge core_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 24 && run_ready !== 1'b1; i++)
			cyc(1);
		chk(POS_W'(run_ready), 7'h01);
		t_res();
		t_wrap();
		t_enable();
		t_fault(1'b0);
		t_fault(1'b1);
		wrap_up();
	end

	// Whole run needs under 3000 cycles; this allows several times that
	initial begin
		#100us;
		mismatches++;
		wrap_up();
	end
endmodule : test_stepper_step_indexer_control
